/* File: hw/pmcfg_params.svh */
// Constants for the power-management configuration register group.
// Assumes a 10 MHz core clock and the processor's 8-bit special function register port.
`ifndef PMCFG_PARAMS_SVH
`define PMCFG_PARAMS_SVH

`define PM_OFS_POWER_CONTROL 8'hC5
`define PM_OFS_WRITE_KEY 8'hC1
`define PM_OFS_IRQ_ENABLE 8'hEC
`define PM_OFS_PERIPHERAL_CONFIG_CFG 8'hF4
`define PM_OFS_BATT_SWITCH 8'hF5
`define PM_OFS_IRQ_FLAGS 8'hF8
`define PM_OFS_SCRATCH_PAD_ONE 8'hFB
`define PM_OFS_SCRATCH_PAD_TWO 8'hFC
`define PM_OFS_SCRATCH_PAD_THREE 8'hFD
`define PM_OFS_SCRATCH_PAD_FOUR 8'hFE
`define PM_OFS_PIN_CFG 8'hFF

`define PM_KEY_UNLOCK 8'hEA
`define PM_RST_BYTE 8'h00
`define PM_RST_PERIPHERAL_CONFIG 8'h60

`define PM_PIN_CAL_EN 7
`define PM_PIN_FSEL_HI 6
`define PM_PIN_FSEL_LO 5
`define PM_PIN_RSVD 4
`define PM_PIN_IRQ1_HI 3
`define PM_PIN_IRQ1_LO 1
`define PM_PIN_IRQ0_EN 0
`define PM_PIN_WR_MASK 8'hEF

`define PM_FLAG_RESTORED 7
`define PM_FLAG_RSVD 4
`define PM_FLAG_SWITCHED 1
`define PM_FLAG_DCIN_LOW 0
`define PM_FLAG_WR_MASK 8'hEF
`define PM_PER_SOURCE 6
`define PM_PER_VDD_OK 5
`define PM_PER_WR_MASK 8'h9F
`define PM_BATT_WR_MASK 8'h03

`define PM_REF_HZ 10000000
`define PM_CAL_HZ_SEL0 1
`define PM_CAL_HZ_SEL1 512
`define PM_CAL_HZ_SEL2 500
`define PM_CAL_HZ_SEL3 16384
`define PM_WIN_LONG_MS 30500
`define PM_WIN_SHORT_MS 244
`define PM_HALF_CYC(hz) ((`PM_REF_HZ) / (2 * (hz)))
`define PM_WIN_CYC(ms) ((`PM_REF_HZ / 1000) * (ms))

`endif

/* File: hw/pmcfg_pkg.sv */
// Types shared by the power-management configuration register group.
// Assumes the constants header is compiled alongside.
package pmcfg_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pmcfg_sfr_req_t;

    typedef struct packed {
        logic vdd_low;
        logic vdcin_low;
        logic vdd_ok;
    } pmcfg_supply_t;

    typedef enum logic [1:0] {
        PMCFG_CAL_IDLE = 2'b01,
        PMCFG_CAL_RUN = 2'b10
    } pmcfg_cal_state_t;

endpackage

/* File: hw/pmcfg_regs.sv */
// Power-management register group: supply switchover, flags, interrupt pin setup
// and the clock calibration output on the shared port pin.
// Assumes the processor core drives the SFR request synchronously to REF_CLK.
`include "pmcfg_params.svh"

module pmcfg_regs #(
    parameter int HALF_SEL0 = `PM_HALF_CYC(`PM_CAL_HZ_SEL0),
    parameter int HALF_SEL1 = `PM_HALF_CYC(`PM_CAL_HZ_SEL1),
    parameter int HALF_SEL2 = `PM_HALF_CYC(`PM_CAL_HZ_SEL2),
    parameter int WIN_LONG = `PM_WIN_CYC(`PM_WIN_LONG_MS),
    parameter int WIN_SHORT = `PM_WIN_CYC(`PM_WIN_SHORT_MS)
) (
    input wire logic REF_CLK, // Core clock, 10 MHz
    input wire logic RST_N, // Asynchronous reset, active low
    input wire pmcfg_pkg::pmcfg_sfr_req_t SFR_REQ, // SFR address, data and strobes
    output logic [7:0] SFR_RDATA, // Read data, one cycle after the read strobe
    input wire pmcfg_pkg::pmcfg_supply_t SUPPLY, // Supply monitor levels
    input wire logic EXT_IRQ0_PIN, // External interrupt 0 pin level
    input wire logic EXT_IRQ1_PIN, // External interrupt 1 pin level
    output logic EXT_IRQ0_REQ, // Interrupt 0 input to the core
    output logic EXT_IRQ1_REQ, // Interrupt 1 input to the core
    output logic EXT_IRQ1_GPIO, // Interrupt 1 pin read as general I/O
    output logic BATTERY_CONTROL, // Battery control input from interrupt 1 pin
    output logic ON_BATTERY, // Supply switched to battery
    output logic CAL_PIN_OUT, // Shared calibration port pin value
    output logic CAL_PIN_OE, // Shared calibration port pin enable
    output logic CAL_WINDOW_END // Pulse at the end of each calibration window
);
    import pmcfg_pkg::*;

    localparam logic [22:0] HALF_SEL3 = 23'(`PM_HALF_CYC(`PM_CAL_HZ_SEL3));

    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        sfr_hit = (addr == ofs);
    endfunction

    logic [7:0] power_control_q;
    logic [7:0] write_key_q;
    logic [7:0] power_irq_enable_q;
    logic [7:0] peripheral_config_q;
    logic [7:0] battery_switch_config_q;
    logic [7:0] power_irq_flags_q;
    logic [7:0] power_irq_flags_d;
    logic [7:0] scratch_q [4];
    logic [7:0] irq_pin_config_q;
    logic [7:0] rdata_d;
    logic on_battery_q;
    logic on_battery_d;
    logic [22:0] half_cnt_q;
    logic [28:0] win_cnt_q;
    logic cal_level_q;
    logic win_end_q;
    logic [7:0] cal_cfg_seen_q;
    pmcfg_cal_state_t cal_state_q;

    wire wr = SFR_REQ.wr;
    wire [7:0] wdata = SFR_REQ.wdata;
    wire [7:0] addr = SFR_REQ.addr;

    // Write decode
    wire wr_pwr = wr && sfr_hit(addr, `PM_OFS_POWER_CONTROL);
    wire wr_key = wr && sfr_hit(addr, `PM_OFS_WRITE_KEY);
    wire wr_ien = wr && sfr_hit(addr, `PM_OFS_IRQ_ENABLE);
    wire wr_per = wr && sfr_hit(addr, `PM_OFS_PERIPHERAL_CONFIG_CFG);
    wire wr_bat = wr && sfr_hit(addr, `PM_OFS_BATT_SWITCH);
    wire wr_flg = wr && sfr_hit(addr, `PM_OFS_IRQ_FLAGS);
    wire key_open = (write_key_q == `PM_KEY_UNLOCK);
    // Protects the calibration output from runaway code
    wire wr_pin = wr && sfr_hit(addr, `PM_OFS_PIN_CFG) && key_open;

    // Pin configuration fields
    wire cal_en = irq_pin_config_q[`PM_PIN_CAL_EN];
    wire [1:0] fsel = irq_pin_config_q[`PM_PIN_FSEL_HI:`PM_PIN_FSEL_LO];
    wire [2:0] irq1_fn = irq_pin_config_q[`PM_PIN_IRQ1_HI:`PM_PIN_IRQ1_LO];
    wire irq0_en = irq_pin_config_q[`PM_PIN_IRQ0_EN];
    wire irq1_en = (irq1_fn[2:1] == 2'h3);
    wire irq1_gpio = (irq1_fn[1:0] == 2'h0);
    wire irq1_battery_control_input = (irq1_fn[1:0] == 2'h1);

    // Switchover policy: 00 low supply, 01 low supply or low dc input, 1X never
    wire [1:0] bat_prg = battery_switch_config_q[1:0];
    wire bat_ctrl_req = irq1_battery_control_input && EXT_IRQ1_PIN;
    wire go_battery = !bat_prg[1] && (SUPPLY.vdd_low || (bat_prg[0] && SUPPLY.vdcin_low) || bat_ctrl_req);
    wire go_mains = SUPPLY.vdd_ok && !SUPPLY.vdd_low && !bat_ctrl_req;
    assign on_battery_d = on_battery_q ? !go_mains : go_battery;
    wire ev_switched = on_battery_d && !on_battery_q;
    wire ev_restored = !on_battery_d && on_battery_q;

    // Hardware set wins over a software clear in the same cycle
    wire [7:0] flag_set = (8'(ev_restored) << `PM_FLAG_RESTORED) | (8'(ev_switched) << `PM_FLAG_SWITCHED)
                          | (8'(SUPPLY.vdcin_low) << `PM_FLAG_DCIN_LOW);
    assign power_irq_flags_d = ((wr_flg ? wdata : power_irq_flags_q) | flag_set) & `PM_FLAG_WR_MASK;

    // Calibration timing
    wire [22:0] half_len = (fsel == 2'h0) ? 23'(HALF_SEL0) :
                           (fsel == 2'h1) ? 23'(HALF_SEL1) :
                           (fsel == 2'h2) ? 23'(HALF_SEL2) : HALF_SEL3;
    wire [28:0] win_len = fsel[1] ? 29'(WIN_SHORT) : 29'(WIN_LONG);
    wire half_done = (half_cnt_q >= half_len - 23'h1);
    wire win_done = (win_cnt_q >= win_len - 29'h1);
    // A change of select restarts the timing so the first period is whole
    wire cal_restart = (irq_pin_config_q != cal_cfg_seen_q);

    // Read mux
    wire [7:0] supply_status = (8'(!on_battery_q) << `PM_PER_SOURCE) | (8'(SUPPLY.vdd_ok) << `PM_PER_VDD_OK);
    wire [7:0] peripheral_config_view = (peripheral_config_q & `PM_PER_WR_MASK) | supply_status;
    assign rdata_d = sfr_hit(addr, `PM_OFS_POWER_CONTROL) ? power_control_q :
                     sfr_hit(addr, `PM_OFS_WRITE_KEY) ? write_key_q :
                     sfr_hit(addr, `PM_OFS_IRQ_ENABLE) ? power_irq_enable_q :
                     sfr_hit(addr, `PM_OFS_PERIPHERAL_CONFIG_CFG) ? peripheral_config_view :
                     sfr_hit(addr, `PM_OFS_BATT_SWITCH) ? battery_switch_config_q :
                     sfr_hit(addr, `PM_OFS_IRQ_FLAGS) ? power_irq_flags_q :
                     sfr_hit(addr, `PM_OFS_SCRATCH_PAD_ONE) ? scratch_q[0] :
                     sfr_hit(addr, `PM_OFS_SCRATCH_PAD_TWO) ? scratch_q[1] :
                     sfr_hit(addr, `PM_OFS_SCRATCH_PAD_THREE) ? scratch_q[2] :
                     sfr_hit(addr, `PM_OFS_SCRATCH_PAD_FOUR) ? scratch_q[3] :
                     sfr_hit(addr, `PM_OFS_PIN_CFG) ? (irq_pin_config_q & `PM_PIN_WR_MASK) :
                     `PM_RST_BYTE;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            power_control_q <= `PM_RST_BYTE;
            write_key_q <= `PM_RST_BYTE;
            power_irq_enable_q <= `PM_RST_BYTE;
            peripheral_config_q <= `PM_RST_PERIPHERAL_CONFIG;
            battery_switch_config_q <= `PM_RST_BYTE;
            irq_pin_config_q <= `PM_RST_BYTE;
        end
        else
        begin
            if (wr_pwr)
                power_control_q <= wdata;
            if (wr_key)
                write_key_q <= wdata;
            if (wr_ien)
                power_irq_enable_q <= wdata;
            if (wr_per)
                peripheral_config_q <= wdata & `PM_PER_WR_MASK;
            if (wr_bat)
                battery_switch_config_q <= wdata & `PM_BATT_WR_MASK;
            if (wr_pin)
                irq_pin_config_q <= wdata & `PM_PIN_WR_MASK;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scratch_q[0] <= `PM_RST_BYTE;
            scratch_q[1] <= `PM_RST_BYTE;
            scratch_q[2] <= `PM_RST_BYTE;
            scratch_q[3] <= `PM_RST_BYTE;
        end
        else if (wr && (addr >= `PM_OFS_SCRATCH_PAD_ONE) && (addr <= `PM_OFS_SCRATCH_PAD_FOUR))
        begin
            scratch_q[2'(addr - `PM_OFS_SCRATCH_PAD_ONE)] <= wdata;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            power_irq_flags_q <= `PM_RST_BYTE;
            on_battery_q <= 1'b0;
            SFR_RDATA <= `PM_RST_BYTE;
        end
        else
        begin
            power_irq_flags_q <= power_irq_flags_d;
            on_battery_q <= on_battery_d;
            if (SFR_REQ.rd)
                SFR_RDATA <= rdata_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            EXT_IRQ0_REQ <= 1'b0;
            EXT_IRQ1_REQ <= 1'b0;
            EXT_IRQ1_GPIO <= 1'b0;
            BATTERY_CONTROL <= 1'b0;
            ON_BATTERY <= 1'b0;
        end
        else
        begin
            EXT_IRQ0_REQ <= irq0_en && EXT_IRQ0_PIN;
            EXT_IRQ1_REQ <= irq1_en && EXT_IRQ1_PIN;
            EXT_IRQ1_GPIO <= irq1_gpio && EXT_IRQ1_PIN;
            BATTERY_CONTROL <= bat_ctrl_req;
            ON_BATTERY <= on_battery_d;
        end
    end

    // Calibration generator: idle while disabled, restarted on any setting change
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cal_state_q <= PMCFG_CAL_IDLE;
            cal_cfg_seen_q <= `PM_RST_BYTE;
            half_cnt_q <= 23'h0;
            win_cnt_q <= 29'h0;
            cal_level_q <= 1'b0;
            win_end_q <= 1'b0;
        end
        else
        begin
            cal_cfg_seen_q <= irq_pin_config_q;
            win_end_q <= 1'b0;
            unique case (cal_state_q)
                PMCFG_CAL_IDLE:
                begin
                    half_cnt_q <= 23'h0;
                    win_cnt_q <= 29'h0;
                    cal_level_q <= 1'b0;
                    if (cal_en)
                        cal_state_q <= PMCFG_CAL_RUN;
                end
                PMCFG_CAL_RUN:
                begin
                    if (!cal_en || cal_restart)
                    begin
                        cal_state_q <= PMCFG_CAL_IDLE;
                    end
                    else
                    begin
                        half_cnt_q <= half_done ? 23'h0 : half_cnt_q + 23'h1;
                        if (half_done)
                            cal_level_q <= !cal_level_q;
                        win_cnt_q <= win_done ? 29'h0 : win_cnt_q + 29'h1;
                        win_end_q <= win_done;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CAL_PIN_OUT <= 1'b0;
            CAL_PIN_OE <= 1'b0;
            CAL_WINDOW_END <= 1'b0;
        end
        else
        begin
            CAL_PIN_OUT <= cal_en && cal_level_q;
            CAL_PIN_OE <= cal_en;
            CAL_WINDOW_END <= win_end_q;
        end
    end

endmodule

/* File: testbench/pmcfg_regs_properties.sv */
// Concurrent checks on the power-management register group ports.
// Assumes one clock domain; shadows the key and pin configuration registers from SFR writes.
module pmcfg_regs_properties
import pmcfg_pkg::*;
(
    input wire logic REF_CLK, // Core clock
    input wire logic RST_N, // Async reset, active low
    input wire pmcfg_sfr_req_t SFR_REQ, // SFR request
    input wire logic [7:0] SFR_RDATA, // SFR read data
    input wire logic EXT_IRQ0_PIN, // Interrupt 0 pin
    input wire logic EXT_IRQ1_PIN, // Interrupt 1 pin
    input wire logic EXT_IRQ0_REQ, // Interrupt 0 request
    input wire logic EXT_IRQ1_REQ, // Interrupt 1 request
    input wire logic EXT_IRQ1_GPIO, // Interrupt 1 pin as I/O
    input wire logic BATTERY_CONTROL, // Battery control
    input wire logic CAL_PIN_OUT, // Calibration pin value
    input wire logic CAL_PIN_OE // Calibration pin enable
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] key_q, key_d, cfg_q, cfg_d;
    wire key_hit = SFR_REQ.wr && SFR_REQ.addr == 8'hC1;
    wire cfg_hit = SFR_REQ.wr && SFR_REQ.addr == 8'hFF && key_q == 8'hEA;
    wire cfg_rd = SFR_REQ.rd && SFR_REQ.addr == 8'hFF;
    assign key_d = key_hit ? SFR_REQ.wdata : key_q;
    // Reserved bit is masked here as the register masks it on both write and read
    assign cfg_d = cfg_hit ? (SFR_REQ.wdata & 8'hEF) : cfg_q;
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            key_q <= 8'h00;
            cfg_q <= 8'h00;
        end
        else
        begin
            key_q <= key_d;
            cfg_q <= cfg_d;
        end
    end
    irq0_follow_a: assert property (EXT_IRQ0_REQ == $past(EXT_IRQ0_PIN && cfg_q[0]))
        else $error("interrupt 0 request does not follow pin and enable");
    irq1_enable_a: assert property (EXT_IRQ1_REQ == $past(EXT_IRQ1_PIN && cfg_q[3:2] == 2'b11))
        else $error("interrupt 1 request does not follow pin and function");
    irq1_gpio_a: assert property (EXT_IRQ1_GPIO == $past(EXT_IRQ1_PIN && cfg_q[2:1] == 2'b00))
        else $error("interrupt 1 I/O view wrong");
    batt_ctrl_a: assert property (BATTERY_CONTROL == $past(EXT_IRQ1_PIN && cfg_q[2:1] == 2'b01))
        else $error("battery control view wrong");
    cal_enable_a: assert property (CAL_PIN_OE == $past(cfg_q[7]))
        else $error("calibration enable does not follow bit 7");
    cal_quiet_a: assert property (!CAL_PIN_OE |-> !CAL_PIN_OUT)
        else $error("calibration pin driven while disabled");
    cfg_read_a: assert property (cfg_rd |=> SFR_RDATA == $past(cfg_q))
        else $error("pin configuration read value wrong");
    unmapped_zero_a: assert property (SFR_REQ.rd && SFR_REQ.addr[7] == 1'b0 |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    cover property (cfg_hit ##3 CAL_PIN_OE);
    cover property (EXT_IRQ1_REQ);
    cover property (BATTERY_CONTROL);
    cover property (SFR_REQ.wr && SFR_REQ.addr == 8'hFF && key_q != 8'hEA);
endmodule

bind pmcfg_regs pmcfg_regs_properties pmcfg_regs_properties_i (.REF_CLK, .RST_N, .SFR_REQ, .SFR_RDATA,
    .EXT_IRQ0_PIN, .EXT_IRQ1_PIN, .EXT_IRQ0_REQ, .EXT_IRQ1_REQ, .EXT_IRQ1_GPIO, .BATTERY_CONTROL,
    .CAL_PIN_OUT, .CAL_PIN_OE);

/* File: testbench/pmcfg_regs_test.sv */
// Self-checking testbench for the power-management register group.
// Assumes short calibration parameters so every waveform and window fits a short run.
module pmcfg_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pmcfg_pkg::*;
    logic ref_clk = 0, rst_n = 0, pin0 = 0, pin1 = 0;
    pmcfg_sfr_req_t req = '0;
    pmcfg_supply_t supply = 3'b001;
    logic [7:0] rdata;
    logic irq0, irq1, gpio, bctl, on_bat, cal_out, cal_oe, win_end;
    int bad_count = 0, comparisons = 0, n;
    logic [31:0] seed = 32'hED5E;
    logic [7:0] d, addrs [10] = '{8'hC5, 8'hEC, 8'hF4, 8'hF5, 8'hF8, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
    logic [7:0] masks [9] = '{8'hFF, 8'hFF, 8'h9F, 8'h03, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    int half_tab [4] = '{20, 9, 10, 305}, win_tab [4] = '{400, 400, 80, 80};

    pmcfg_regs #(.HALF_SEL0(20), .HALF_SEL1(9), .HALF_SEL2(10), .WIN_LONG(400), .WIN_SHORT(80)) pmcfg_regs_i (
        .REF_CLK(ref_clk), .RST_N(rst_n), .SFR_REQ(req), .SFR_RDATA(rdata), .SUPPLY(supply),
        .EXT_IRQ0_PIN(pin0), .EXT_IRQ1_PIN(pin1), .EXT_IRQ0_REQ(irq0), .EXT_IRQ1_REQ(irq1),
        .EXT_IRQ1_GPIO(gpio), .BATTERY_CONTROL(bctl), .ON_BATTERY(on_bat), .CAL_PIN_OUT(cal_out),
        .CAL_PIN_OE(cal_oe), .CAL_WINDOW_END(win_end));

    always #50 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] reg_exp(input int i, input logic [7:0] v);
        // Peripheral status bits are live: on mains with the supply good
        return (v & masks[i]) | (i == 2 ? 8'h60 : 8'h00);
    endfunction

    task automatic tick();
        @(posedge ref_clk);
        #5;
    endtask

    task automatic tally(input logic miss, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (miss)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        tally(got !== exp, 32'(got), 32'(exp));
    endtask

    task automatic check_pins(input logic [3:0] got, input logic [3:0] exp);
        tally(got !== exp, 32'(got), 32'(exp));
    endtask

    task automatic check_count(input int got, input int exp);
        tally(got != exp, got, exp);
    endtask

    // Every access leaves one idle cycle so no strobe is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        req = '{a, v, 1'b1, 1'b0};
        tick();
        req = '0;
        tick();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{a, 8'h00, 1'b0, 1'b1};
        tick();
        req = '0;
        check_data(rdata, exp);
        tick();
    endtask

    task automatic cfg(input logic [7:0] v);
        wr(8'hC1, 8'hEA);
        wr(8'hFF, v);
        wr(8'hC1, 8'h00);
    endtask

    // Mode 0: next pin toggle, 1: next window pulse, 2: next switchover change
    task automatic gap(input int m, output int cnt);
        logic lv;
        lv = m == 0 ? cal_out : on_bat;
        cnt = 0;
        do
        begin
            tick();
            cnt++;
        end while ((m == 1 ? win_end !== 1'b1 : (m == 0 ? cal_out : on_bat) === lv) && cnt < 2000);
    endtask

    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #4000000;
        bad_count++;
        complete_run();
    end

    initial
    begin
        repeat (20) @(posedge ref_clk);
        #5 rst_n = 1;
        tick();
        for (int i = 0; i < 10; i++)
            rd(addrs[i], i == 2 ? 8'h60 : 8'h00);
        for (int k = 0; k < 24; k++)
        begin
            seed = lfsr(seed);
            d = seed[15:8];
            wr(addrs[seed % 9], d);
            rd(addrs[seed % 9], reg_exp(seed % 9, d));
            wr({1'b0, seed[22:16]}, d);
            rd({1'b0, seed[22:16]}, 8'h00);
        end
        wr(8'hF5, 8'h02);
        wr(8'hFF, 8'hFF);
        rd(8'hFF, 8'h00);
        cfg(d & 8'h7F);
        rd(8'hFF, d & 8'h6F);
        wr(8'hFF, ~d);
        rd(8'hFF, d & 8'h6F);
        for (int c = 0; c < 16; c++)
        begin
            cfg(c[7:0]);
            for (int p = 0; p < 4; p++)
            begin
                pin0 = p[0];
                pin1 = p[1];
                tick();
                tick();
                check_pins({irq0, irq1, gpio, bctl}, {p[0] & c[0], p[1] & (c[3:2] == 2'b11),
                    p[1] & (c[2:1] == 2'b00), p[1] & (c[2:1] == 2'b01)});
            end
        end
        pin0 = 0;
        pin1 = 0;
        for (int s = 0; s < 4; s++)
        begin
            cfg({1'b1, s[1:0], 5'h00});
            check_pins({3'b000, cal_oe}, 4'h1);
            repeat (2) gap(0, n);
            gap(0, n);
            check_count(n, half_tab[s]);
            gap(1, n);
            gap(1, n);
            check_count(n, win_tab[s]);
        end
        cfg(8'h00);
        check_pins({2'b00, cal_oe, cal_out}, 4'h0);
        wr(8'hF5, 8'h00);
        wr(8'hF8, 8'h00);
        supply = 3'b100;
        gap(2, n);
        check_pins({3'b000, on_bat}, 4'h1);
        tick();
        rd(8'hF8, 8'h02);
        supply = 3'b001;
        gap(2, n);
        check_pins({3'b000, on_bat}, 4'h0);
        tick();
        rd(8'hF8, 8'h82);
        wr(8'hF5, 8'h02);
        supply = 3'b100;
        repeat (10) tick();
        check_pins({3'b000, on_bat}, 4'h0);
        // Low dc input held while software clears: the hardware set must win
        supply = 3'b011;
        wr(8'hF8, 8'h00);
        rd(8'hF8, 8'h01);
        // Reset in mid-run returns the registers to their defaults
        supply = 3'b001;
        rst_n = 0;
        tick();
        rst_n = 1;
        tick();
        rd(8'hF8, 8'h00);
        rd(8'hF5, 8'h00);
        rd(8'hF4, 8'h60);
        complete_run();
    end
endmodule
